// ---- hw/bit_fifo.sv ----
// small synchronous fifo for received transmit bits
// assumes one clock; push and pop may occur in the same cycle
`timescale 1ns/1ns
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and fill bookkeeping
    always_comb begin
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; contents are only read while counted valid
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule : bit_fifo

// ---- hw/burst_tx_consts.svh ----
// timing counts and buffer depth for the burst transmit sequencer
// assumes the master clock (clk_sys) is the device's sequencing clock
`ifndef BURST_TX_CONSTS_SVH
`define BURST_TX_CONSTS_SVH

// master-clock periods, one unit of t1
`define CAL_DONE_CYCLES     4097
`define FIRST_EDGE_CYCLES   3
`define BIT_CLOCK_PERIOD    64
`define BIT_CLOCK_HALF      32
// ramp-down after the last symbol, in half bit-clock periods (7.5 periods)
`define RAMP_DOWN_HALVES    15
`define READY_AFTER_CYCLES  30
// delay of the burst copy through the modulation pipeline, in master cycles
`define PIPE_DELAY_CYCLES   8
`define FIFO_DEPTH          16

`endif

// ---- hw/burst_tx_pkg.sv ----
// types shared by the burst transmit sequencer, its checker and its bench
// assumes burst_tx_consts.svh is compiled alongside
package burst_tx_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_MOD_TEST,
        MODE_FACTORY
    } op_mode_type;

    typedef enum {
        ST_SLEEP,
        ST_CALIBRATE,
        ST_IDLE,
        ST_LEAD,
        ST_ACTIVE,
        ST_RAMP_DOWN,
        ST_FINISH
    } seq_state_type;

    // status seen by the baseband side
    typedef struct packed {
        logic ready;
        logic ramp_up;
        logic ramp_down;
        logic sleeping;
    } tx_status_type;

endpackage : burst_tx_pkg

// ---- hw/burst_tx_seq.sv ----
// burst transmit sequencer: wake, calibration, bit clock and ramp control
// assumes wake, burst request, bits and mode pins come from outside clk_sys
// Operation
// - decode mode pins: normal, modulator test, reserved
// - ready within 4097 cycles after wake sampled
// - first bit clock rise three cycles after request; the code rises two cycles after the filtered request
// - bit clock 64 cycles, bits taken falling
// - ramp-down lasts seven and half bit periods
// - ready within 30 cycles of last falling edge
// - sleep while wake low, calibrate when high
// - ramp up on request high, down low
// - delayed copy of request through pipeline; the code delays the active state (ST_ACTIVE), not the request
`timescale 1ns/1ns
`include "burst_tx_consts.svh"
module burst_tx_seq #(
    parameter int CAL_CYCLES = `CAL_DONE_CYCLES,
    parameter int PIPE_DELAY = `PIPE_DELAY_CYCLES,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    input  wire logic                      wake,
    input  wire logic                      burst_request,
    input  wire logic                      serial_tx_bits,
    input  wire logic                      mode_select_first,
    input  wire logic                      mode_select_second,
    output logic                           serial_bit_clock,
    output logic                           ready,
    output logic                           burst_delayed_out,
    output burst_tx_pkg::op_mode_type      op_mode,
    output logic                           modulator_test_mode,
    output burst_tx_pkg::tx_status_type    status,
    output logic                           symbol_valid,
    input  wire logic                      symbol_ready,
    output logic                           symbol_bit,
    output logic                           bit_overflow
);
    import burst_tx_pkg::*;

    // three-stage samplers; second and third stages must agree
    logic [2:0] wake_s_q, req_s_q, bit_s_q, m1_s_q, m2_s_q;
    logic       wake_f_q, req_f_q, bit_f_q, m1_f_q, m2_f_q;

    function automatic logic filt(input logic [2:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[1] : prev;
    endfunction : filt

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wake_s_q <= '0;
            req_s_q  <= '0;
            bit_s_q  <= '0;
            m1_s_q   <= '0;
            m2_s_q   <= '0;
            wake_f_q <= 1'b0;
            req_f_q  <= 1'b0;
            bit_f_q  <= 1'b0;
            m1_f_q   <= 1'b0;
            m2_f_q   <= 1'b0;
        end else begin
            // sampling on rising edges of the master clock
            wake_s_q <= {wake_s_q[1:0], wake};
            req_s_q  <= {req_s_q[1:0], burst_request};
            bit_s_q  <= {bit_s_q[1:0], serial_tx_bits};
            m1_s_q   <= {m1_s_q[1:0], mode_select_first};
            m2_s_q   <= {m2_s_q[1:0], mode_select_second};
            wake_f_q <= filt(wake_s_q, wake_f_q);
            req_f_q  <= filt(req_s_q, req_f_q);
            bit_f_q  <= filt(bit_s_q, bit_f_q);
            m1_f_q   <= filt(m1_s_q, m1_f_q);
            m2_f_q   <= filt(m2_s_q, m2_f_q);
        end
    end

    // mode decode; first pin high wins regardless of the second
    op_mode_type mode_q, mode_d;
    always_comb begin
        if (m1_f_q) begin
            mode_d = MODE_FACTORY;
        end else if (m2_f_q) begin
            mode_d = MODE_MOD_TEST;
        end else begin
            mode_d = MODE_NORMAL;
        end
    end

    // sequencer state
    seq_state_type st_q, st_d;
    logic [12:0]   cnt_q, cnt_d;      // calibration / lead / tail counter
    logic [5:0]    ph_q, ph_d;        // phase within a bit-clock half period
    logic          bclk_q, bclk_d;
    logic [3:0]    half_q, half_d;    // ramp-down half periods
    logic          rdy_q, rdy_d;
    logic          take_bit;

    localparam logic [12:0] CAL_LAST  = 13'(CAL_CYCLES - 8);
    localparam logic [12:0] HALF_LAST = 13'(`BIT_CLOCK_HALF - 1);
    localparam logic [12:0] TAIL_LAST = 13'(`READY_AFTER_CYCLES - 4);

    // bit clock falls when the high half completes
    assign take_bit = bclk_q && (ph_q == 6'(`BIT_CLOCK_HALF - 1));

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q + 13'h1;
        ph_d   = ph_q;
        bclk_d = bclk_q;
        half_d = half_q;
        rdy_d  = rdy_q;
        // bit clock runs through the burst and the ramp-down
        if (st_q == ST_ACTIVE || st_q == ST_RAMP_DOWN) begin
            ph_d = (ph_q == 6'(`BIT_CLOCK_HALF - 1)) ? 6'h0 : ph_q + 6'h1;
            if (ph_q == 6'(`BIT_CLOCK_HALF - 1)) begin
                bclk_d = !bclk_q;
            end
        end
        case (st_q)
            ST_SLEEP: begin
                rdy_d = 1'b0;
                if (wake_f_q) begin
                    st_d  = ST_CALIBRATE;
                    cnt_d = 13'h0;
                end
            end
            ST_CALIBRATE: begin
                if (cnt_q >= CAL_LAST) begin
                    st_d  = ST_IDLE;
                    rdy_d = 1'b1;
                end
            end
            ST_IDLE: begin
                if (req_f_q && mode_q != MODE_FACTORY) begin
                    st_d  = ST_LEAD;
                    rdy_d = 1'b0;
                    cnt_d = 13'h0;
                end
            end
            ST_LEAD: begin
                // lead lasts one cycle; the sampler latency comes before it
                st_d   = ST_ACTIVE;
                bclk_d = 1'b1;
                ph_d   = 6'h0;
            end
            ST_ACTIVE: begin
                if (!req_f_q && take_bit) begin
                    st_d   = ST_RAMP_DOWN;
                    half_d = 4'h0;
                end
            end
            ST_RAMP_DOWN: begin
                if (ph_q == 6'(`BIT_CLOCK_HALF - 1)) begin
                    half_d = half_q + 4'h1;
                    // last fall of the ramp; the final low half runs in finish so
                    // ready can rise within its bound before the ramp is over
                    if (half_q == 4'(`RAMP_DOWN_HALVES - 2)) begin
                        st_d   = ST_FINISH;
                        bclk_d = 1'b0;
                        cnt_d  = 13'h0;
                    end
                end
            end
            ST_FINISH: begin
                // clock held low; count from the final falling edge
                if (cnt_q >= TAIL_LAST) begin
                    rdy_d = 1'b1;
                end
                if (cnt_q >= HALF_LAST) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_SLEEP;
        endcase
        // sleep overrides every state
        if (!wake_f_q) begin
            st_d   = ST_SLEEP;
            bclk_d = 1'b0;
            rdy_d  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q   <= ST_SLEEP;
            cnt_q  <= '0;
            ph_q   <= '0;
            bclk_q <= 1'b0;
            half_q <= '0;
            rdy_q  <= 1'b0;
            mode_q <= MODE_NORMAL;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            ph_q   <= ph_d;
            bclk_q <= bclk_d;
            half_q <= half_d;
            rdy_q  <= rdy_d;
            mode_q <= mode_d;
        end
    end

    // delayed burst copy tracks the modulator pipeline so amplifiers key in step
    logic [PIPE_DELAY-1:0] pipe_q, pipe_d;
    always_comb begin
        pipe_d = {pipe_q[PIPE_DELAY-2:0], (st_q == ST_ACTIVE)};
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= pipe_d;
        end
    end

    // bits taken on the falling bit-clock edge go into the symbol buffer;
    // a stalled consumer makes the buffer fill and flags lost bits
    logic in_ready;
    logic ovf_q, ovf_d;
    logic push;
    // the fall that sees the request low starts the ramp and carries no symbol
    assign push = take_bit && st_q == ST_ACTIVE && req_f_q;
    always_comb begin
        ovf_d = ovf_q | (push & !in_ready);
        if (st_q == ST_IDLE && req_f_q) begin
            ovf_d = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_d;
        end
    end

    bit_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (in_ready),
        .in_data   (bit_f_q),
        .out_valid (symbol_valid),
        .out_ready (symbol_ready),
        .out_data  (symbol_bit)
    );

    assign serial_bit_clock    = bclk_q;
    assign ready               = rdy_q;
    assign burst_delayed_out   = pipe_q[PIPE_DELAY-1];
    assign op_mode             = mode_q;
    assign modulator_test_mode = (mode_q == MODE_MOD_TEST);
    assign bit_overflow        = ovf_q;
    assign status.ready        = rdy_q;
    assign status.ramp_up      = (st_q == ST_LEAD) || (st_q == ST_ACTIVE);
    assign status.ramp_down    = (st_q == ST_RAMP_DOWN) || (st_q == ST_FINISH);
    assign status.sleeping     = (st_q == ST_SLEEP);
endmodule : burst_tx_seq

// ---- test/burst_ctrl_model.sv ----
// baseband controller model: one burst of bits per start pulse
// assumes bits are taken on bit-clock falls; outputs move 2 ns after clk_sys
`timescale 1ns/1ns
module burst_ctrl_model (
    input  wire logic        clk_sys,
    input  wire logic        start,
    input  wire logic [4:0]  nbits,
    input  wire logic [19:0] pattern,
    input  wire logic [6:0]  lag,
    input  wire logic        serial_bit_clock,
    output logic             burst_request,
    output logic             serial_tx_bits,
    output logic             busy
);
    logic go, rise, fall, clk_q, start_n, bclk_n;
    int   falls, wait_n;
    initial begin
        burst_request = 1'b0;
        serial_tx_bits = 1'b0;
        busy = 1'b0;
        clk_q = 1'b0;
        start_n = 1'b0;
        bclk_n = 1'b0;
    end
    // latch on the falling edge so the rising edge sees settled values, not a race
    always @(negedge clk_sys) begin
        start_n = start;
        bclk_n = serial_bit_clock;
    end
    // act 2 ns after the rising edge so the bench never races us
    always @(posedge clk_sys) begin
        go = start_n;
        rise = bclk_n && !clk_q;
        fall = !bclk_n && clk_q;
        clk_q = bclk_n;
        #2;
        if (busy && fall) falls++;
        if (go && !busy) begin
            busy = 1'b1;
            falls = 0;
            wait_n = 0;
            burst_request = 1'b1;
            serial_tx_bits = pattern[0];
        end else if (busy && falls < nbits) begin
            if (rise) serial_tx_bits = pattern[falls];
        end else if (busy && wait_n < lag) begin
            wait_n++;
            serial_tx_bits = ~serial_tx_bits;
        end else begin
            // late drop stays far inside the allowed hold window
            busy = 1'b0;
            burst_request = 1'b0;
            serial_tx_bits = ~serial_tx_bits;
        end
    end
endmodule : burst_ctrl_model

// ---- test/burst_tx_seq_asserts.sv ----
// checker: timing relations at the sequencer's ports
// assumes it is bound onto burst_tx_seq
`timescale 1ns/1ns
module burst_tx_seq_asserts #(
    parameter int CAL_CYCLES = 4097
) (
    input wire logic                        clk_sys,
    input wire logic                        resetn,
    input wire logic                        wake,
    input wire logic                        burst_request,
    input wire logic                        mode_select_first,
    input wire logic                        mode_select_second,
    input wire logic                        serial_bit_clock,
    input wire logic                        ready,
    input wire burst_tx_pkg::op_mode_type   op_mode,
    input wire logic                        modulator_test_mode,
    input wire burst_tx_pkg::tx_status_type status
);
    import burst_tx_pkg::*;
    localparam int CAL_MAX = CAL_CYCLES + 8;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [5:0]  run_q, run_d, gap_q, gap_d;
    logic [15:0] cal_q, cal_d;
    logic        clk_q, wake_q, arm_q, arm_d;
    // run and gap counters saturate so long idle spells cannot wrap them
    always_comb begin
        run_d = (serial_bit_clock != clk_q) ? 6'h00 : run_q + 6'(run_q != 6'h3f);
        gap_d = (clk_q && !serial_bit_clock) ? 6'h00 : gap_q + 6'(gap_q != 6'h3f);
        arm_d = wake && !ready && (arm_q || !wake_q);
        cal_d = arm_q ? cal_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {run_q, gap_q} <= {6'h3f, 6'h3f};
            {cal_q, clk_q, wake_q, arm_q} <= {16'h0000, 3'h0};
        end else begin
            {run_q, gap_q} <= {run_d, gap_d};
            {cal_q, clk_q, wake_q, arm_q} <= {cal_d, serial_bit_clock, wake, arm_d};
        end
    end
    AST_MODE_DECODE: assert property ($stable({mode_select_first, mode_select_second}) [*8]
        |-> op_mode == (mode_select_first ? MODE_FACTORY
            : (mode_select_second ? MODE_MOD_TEST : MODE_NORMAL))) else $error("mode");
    AST_TEST_FLAG: assert property ($stable(op_mode) [*3]
        |-> modulator_test_mode == (op_mode == MODE_MOD_TEST)) else $error("test flag");
    AST_CAL_BOUND: assert property (cal_q <= 16'(CAL_MAX)) else $error("slow ready");
    AST_FIRST_RISE: assert property ($rose(burst_request) && ready && op_mode == MODE_NORMAL
        |-> !serial_bit_clock [*3] ##[1:8] serial_bit_clock) else $error("first rise");
    AST_HIGH_TIME: assert property ($fell(serial_bit_clock) |-> run_q == 6'd31)
        else $error("high time");
    AST_LOW_TIME: assert property ($rose(serial_bit_clock) && run_q < 6'd40
        |-> run_q == 6'd31) else $error("low time");
    AST_READY_END: assert property (gap_q == 6'd31 && !serial_bit_clock |-> ready)
        else $error("ready late");
    AST_SLEEP: assert property (!wake [*8] |-> status.sleeping && !ready)
        else $error("not asleep");
endmodule : burst_tx_seq_asserts
bind burst_tx_seq burst_tx_seq_asserts #(.CAL_CYCLES(CAL_CYCLES)) chk (.clk_sys, .resetn,
    .wake, .burst_request, .mode_select_first, .mode_select_second, .serial_bit_clock,
    .ready, .op_mode, .modulator_test_mode, .status);

// ---- test/burst_tx_seq_bench.sv ----
// bench: bursts of random bits, buffer stall, modes, sleep
// assumes calibration cut to 64 cycles
`timescale 1ns/1ns
module burst_tx_seq_bench;
    import burst_tx_pkg::*;
    logic          clk_sys, resetn, wake, start, symbol_ready, clk_q, burst_delayed_out_seen, busy;
    logic          mode_select_first, mode_select_second, burst_request, serial_tx_bits;
    logic          serial_bit_clock, ready, burst_delayed_out, modulator_test_mode;
    logic          symbol_valid, symbol_bit, bit_overflow;
    logic          up_seen, down_seen;
    logic [4:0]    nbits;
    logic [19:0]   pattern;
    logic [6:0]    lag;
    op_mode_type   op_mode;
    tx_status_type status;
    int            errors, n_compared, falls, seed, i, k;
    logic          got[$];
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    burst_tx_seq #(.CAL_CYCLES(64)) uut (.clk_sys, .resetn, .wake, .burst_request,
        .serial_tx_bits, .mode_select_first, .mode_select_second, .serial_bit_clock,
        .ready, .burst_delayed_out, .op_mode, .modulator_test_mode, .status,
        .symbol_valid, .symbol_ready, .symbol_bit, .bit_overflow);
    burst_ctrl_model ctl (.clk_sys, .start, .nbits, .pattern, .lag, .serial_bit_clock,
        .burst_request, .serial_tx_bits, .busy);
    // watch falls, ramps, the delayed copy and bits leaving the buffer;
    // mid-cycle sampling sees settled outputs and exactly the pops of the next edge
    always @(negedge clk_sys) begin
        if (clk_q && !serial_bit_clock) falls++;
        clk_q = serial_bit_clock;
        if (burst_delayed_out === 1'b1) burst_delayed_out_seen = 1'b1;
        if (status.ramp_up === 1'b1) up_seen = 1'b1;
        if (status.ramp_down === 1'b1) down_seen = 1'b1;
        if (symbol_valid === 1'b1 && symbol_ready) got.push_back(symbol_bit);
    end
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask : step
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic report_and_stop;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic settle(input int lim);
        int n;
        n = 0;
        while (busy !== 1'b0 || ready !== 1'b1) begin
            n++;
            if (n > lim) check(1'b0, "wait ran out");
            if (n > lim) report_and_stop();
            step();
        end
    endtask : settle
    function automatic op_mode_type exp_mode(input logic [1:0] m);
        return m[1] ? MODE_FACTORY : (m[0] ? MODE_MOD_TEST : MODE_NORMAL);
    endfunction : exp_mode
    // stall holds the buffer's consumer off until the burst is over
    task automatic burst(input int nb, input int lg, input logic stall);
        nbits = nb[4:0];
        pattern = 20'($random(seed));
        lag = lg[6:0];
        symbol_ready = ~stall;
        falls = 0;
        burst_delayed_out_seen = 1'b0;
        {up_seen, down_seen} = 2'h0;
        got.delete();
        start = 1'b1;
        step();
        start = 1'b0;
        step();
        settle(3000);
        symbol_ready = 1'b1;
        repeat (20) step();
        check(falls == nb + 8, "fall count");
        check(burst_delayed_out_seen, "no burst copy");
        check(up_seen === 1'b1 && down_seen === 1'b1, "no ramp");
        check(status.ramp_up === 1'b0 && status.ramp_down === 1'b0, "ramp left on");
        check(got.size() == (nb > 16 ? 16 : nb), "bit count");
        for (i = 0; i < got.size(); i++) check(got[i] === pattern[i], "bit value");
        check(bit_overflow === (nb > 16), "overflow flag");
    endtask : burst
    initial begin
        seed = 32'h3fef3878;
        {errors, n_compared} = {32'h0, 32'h0};
        {resetn, wake, start, symbol_ready} = 4'h1;
        {mode_select_first, mode_select_second} = 2'h0;
        {nbits, pattern, lag} = 32'h0;
        repeat (10) step();
        resetn = 1'b1;
        check(status.sleeping === 1'b1 && ready === 1'b0, "awake at reset");
        wake = 1'b1;
        settle(100);
        $display("wake test ended");
        burst(1, 0, 1'b0);
        for (k = 0; k < 3; k++) burst(2 + $unsigned($random(seed)) % 14,
            $unsigned($random(seed)) % 41, 1'b0);
        burst(20, 3, 1'b1);
        burst(16, 3, 1'b1);
        $display("burst tests ended");
        for (k = 0; k < 4; k++) begin
            {mode_select_first, mode_select_second} = k[1:0];
            repeat (12) step();
            check(op_mode === exp_mode(k[1:0]), "mode");
            check(modulator_test_mode === (k == 1), "test flag");
        end
        {mode_select_first, mode_select_second} = 2'h0;
        $display("mode test ended");
        wake = 1'b0;
        repeat (12) step();
        check(status.sleeping === 1'b1 && ready === 1'b0, "not asleep");
        wake = 1'b1;
        settle(100);
        $display("sleep test ended");
        report_and_stop();
    end
endmodule : burst_tx_seq_bench
